// file: hdl/tmc_timer.v
// sixteen-bit timer/counter with prescaler, external clock input and overflow interrupt
//
// Behaviour
// (R1) 8-bit control register, bits 7:6 zero
// (R2) prescale code selects divide by 1,2,4,8
// (R3) counter mode counts external rising edges only
// (R4) after enable, wait for falling edge first
// (R5) oscillator enable bit starts/stops crystal oscillator
// (R6) oscillator disabled draws no power
// (R7) oscillator keeps running during sleep
// (R8) software waits for crystal start-up itself
// (R9) count wraps from FFFFh to 0000h
// (R10) wrap sets the overflow flag
// (R11) overflow enable bit masks the interrupt
// (R12) run enable starts and stops timer
// (R13) source select: instruction cycle or external
// (R14) oscillator enabled forces both pins input
// (R15) sync bit chooses synchronised or raw input
// (R16) prescaler precedes counter; async counts in sleep
//
// The APB register port was left to the implementer.
`include "tmc_regs.vh"

module tmc_timer (
    // clock and reset
    input wire i_clock,
    input wire i_rst_n,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // instruction cycle tick and sleep state of the core
    input wire i_instr_tick,
    input wire i_sleep,
    // external clock pin and oscillator pins
    input wire i_ext_clock_pin,
    input wire i_osc_input_pin,
    output reg o_osc_run,
    output reg o_osc_pins_input,
    // interrupt
    output reg o_irq
);

    ////////////////////////////////////////////////////////////////////////
    reg [5:0] ctrl_r;
    reg [15:0] count_r;
    reg [15:0] count_nxt;
    reg ovf_flag_r;
    reg ovf_en_r;
    reg ext_sync1_r;
    reg ext_sync2_r;
    reg armed_r;
    reg [2:0] ps_cnt_r;
    reg [2:0] ps_cnt_nxt;
    reg src_tick;
    reg cnt_tick;
    reg wrap;
    reg ext_level;
    reg [31:0] rdata;
    reg addr_ok;
    reg [1:0] bus_state_r;
    reg [1:0] bus_state_nxt;

    // one-hot bus phases
    localparam [1:0] BUS_IDLE = 2'b01;
    localparam [1:0] BUS_ACCESS = 2'b10;

    // a write lands only in the access cycle that follows a seen setup
    wire wr_acc = i_psel & i_penable & i_pwrite & (bus_state_r == BUS_ACCESS);
    wire rd_set = i_psel & ~i_penable;
    wire wr_ctrl = wr_acc && (i_paddr == `TMC_CTRL_ADDR);
    wire wr_cnt_lo = wr_acc && (i_paddr == `TMC_CNT_LO_ADDR);
    wire wr_cnt_hi = wr_acc && (i_paddr == `TMC_CNT_HI_ADDR);
    wire wr_flags = wr_acc && (i_paddr == `TMC_FLAGS_ADDR);
    wire wr_enables = wr_acc && (i_paddr == `TMC_ENABLES_ADDR);
    wire run = ctrl_r[`TMC_RUN_BIT];
    wire ext_mode = ctrl_r[`TMC_CS_BIT];
    wire osc_en = ctrl_r[`TMC_OSC_EN_BIT];
    wire [1:0] ps_sel = {ctrl_r[`TMC_PS_HI_BIT], ctrl_r[`TMC_PS_LO_BIT]};

    // prescale code to terminal count of the divider
    function [2:0] ps_limit;
        input [1:0] code;
        begin
            case (code)
                2'b11: ps_limit = `TMC_PS_LIM_DIV8;
                2'b10: ps_limit = `TMC_PS_LIM_DIV4;
                2'b01: ps_limit = `TMC_PS_LIM_DIV2;
                default: ps_limit = `TMC_PS_LIM_DIV1;
            endcase
        end
    endfunction

    function known_addr;
        input [11:0] a;
        begin
            case (a)
                `TMC_CTRL_ADDR, `TMC_CNT_LO_ADDR, `TMC_CNT_HI_ADDR: known_addr = 1'b1;
                `TMC_FLAGS_ADDR, `TMC_ENABLES_ADDR, `TMC_SLEEP_ADDR: known_addr = 1'b1;
                default: known_addr = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // edge source: crystal pin when the oscillator runs, else the clock pin
    always @* begin
        ext_level = osc_en ? i_osc_input_pin : i_ext_clock_pin;
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            ext_sync1_r <= 1'b0;
            ext_sync2_r <= 1'b0;
        end else begin
            ext_sync1_r <= ext_level;
            ext_sync2_r <= ext_sync1_r;
        end
    end

    // unsynchronised mode takes the pin level straight into the edge detector,
    // safe only because pins arrive synchronous to i_clock; the synchronised
    // path costs two cycles of latency but tolerates a free-running source
    wire ext_cur = ctrl_r[`TMC_SYNC_N_BIT] ? ext_level : ext_sync2_r; // R15
    reg ext_cur_d_r;
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            ext_cur_d_r <= 1'b0;
        end else begin
            ext_cur_d_r <= ext_cur;
        end
    end
    wire ext_rise = ext_cur & ~ext_cur_d_r; // R3
    wire ext_fall = ~ext_cur & ext_cur_d_r;

    // armed once a falling edge follows enabling counter mode
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            armed_r <= 1'b0;
        end else if (!(run && ext_mode)) begin
            armed_r <= 1'b0; // R4
        end else if (ext_fall) begin
            armed_r <= 1'b1; // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source tick, prescaler and counter
    always @* begin
        if (ext_mode) begin
            src_tick = armed_r & ext_rise; // R13 R4
        end else begin
            src_tick = i_instr_tick & ~i_sleep; // R13
        end
        // synchronised counting stops in sleep; unsynchronised keeps going
        if (ext_mode && i_sleep && !ctrl_r[`TMC_SYNC_N_BIT]) begin
            src_tick = 1'b0; // R16
        end
        if (!run) begin
            src_tick = 1'b0; // R12
        end
    end

    // divider in front of the counter
    always @* begin
        ps_cnt_nxt = ps_cnt_r;
        cnt_tick = 1'b0;
        if (src_tick) begin
            if (ps_cnt_r >= ps_limit(ps_sel)) begin
                ps_cnt_nxt = 3'h0;
                cnt_tick = 1'b1; // R2 R16
            end else begin
                ps_cnt_nxt = ps_cnt_r + 3'h1;
            end
        end
    end

    // a software write to either byte wins for that byte over an increment in the same cycle; the other byte takes the increment
    always @* begin
        count_nxt = count_r;
        wrap = 1'b0;
        if (cnt_tick) begin
            count_nxt = count_r + 16'h0001; // R9
            wrap = (count_r == `TMC_CNT_MAX); // R9
        end
        if (wr_cnt_lo) begin
            count_nxt = {count_nxt[15:8], i_pwdata[7:0]};
        end
        if (wr_cnt_hi) begin
            count_nxt = {i_pwdata[7:0], count_nxt[7:0]};
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            ps_cnt_r <= 3'h0;
            count_r <= `TMC_CNT_RST;
        end else begin
            // writing the control register restarts the prescaler
            if (wr_ctrl) begin
                ps_cnt_r <= 3'h0;
            end else begin
                ps_cnt_r <= ps_cnt_nxt;
            end
            count_r <= count_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and interrupt
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            ctrl_r <= `TMC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= i_pwdata[5:0]; // R1 R5
        end
    end

    // mask of the same layout as the flags
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            ovf_en_r <= 1'b0;
        end else if (wr_enables) begin
            ovf_en_r <= i_pwdata[`TMC_OVF_BIT]; // R11
        end
    end

    // set wins over a write-one clear in the same cycle
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            ovf_flag_r <= 1'b0;
        end else if (wrap) begin
            ovf_flag_r <= 1'b1; // R10
        end else if (wr_flags && i_pwdata[`TMC_OVF_BIT]) begin
            ovf_flag_r <= 1'b0;
        end
    end

    always @* begin
        addr_ok = known_addr(i_paddr);
        case (i_paddr)
            `TMC_CTRL_ADDR: rdata = {26'h000_0000, ctrl_r}; // R1
            `TMC_CNT_LO_ADDR: rdata = {24'h00_0000, count_r[7:0]};
            `TMC_CNT_HI_ADDR: rdata = {24'h00_0000, count_r[15:8]};
            `TMC_FLAGS_ADDR: rdata = {31'h0000_0000, ovf_flag_r};
            `TMC_ENABLES_ADDR: rdata = {31'h0000_0000, ovf_en_r};
            `TMC_SLEEP_ADDR: rdata = {31'h0000_0000, i_sleep};
            default: rdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus phases: every setup cycle is followed by exactly one access cycle
    always @* begin
        case (bus_state_r)
            BUS_IDLE: begin
                bus_state_nxt = rd_set ? BUS_ACCESS : BUS_IDLE;
            end
            BUS_ACCESS: begin
                // a master that holds penable longer is still answered only once
                bus_state_nxt = BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            bus_state_r <= bus_state_nxt;
        end
    end

    // answer one cycle after setup: pready rises in the first access cycle
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= (bus_state_nxt == BUS_ACCESS);
            o_pslverr <= (bus_state_nxt == BUS_ACCESS) & ~addr_ok;
            if (rd_set && !i_pwrite) begin
                o_prdata <= rdata;
            end
        end
    end

    // status outputs follow their registers by one cycle
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
            o_osc_run <= 1'b0;
            o_osc_pins_input <= 1'b0;
        end else begin
            // registered one cycle after the flag or mask changes
            o_irq <= ovf_flag_r & ovf_en_r; // R11
            // oscillator enable gates power and is independent of sleep
            o_osc_run <= osc_en; // R5 R6 R7
            o_osc_pins_input <= osc_en; // R14
        end
    end

endmodule

// file: pkg/tmc_regs.vh
// register map, field positions and reset values of the sixteen-bit timer/counter
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
`define TMC_CTRL_ADDR 12'h010
`define TMC_CNT_LO_ADDR 12'h014
`define TMC_CNT_HI_ADDR 12'h018
`define TMC_FLAGS_ADDR 12'h01C
`define TMC_ENABLES_ADDR 12'h020
`define TMC_SLEEP_ADDR 12'h024
`define TMC_CTRL_RST 6'h00
`define TMC_CTRL_W 6
`define TMC_RUN_BIT 0
`define TMC_CS_BIT 1
`define TMC_SYNC_N_BIT 2
`define TMC_OSC_EN_BIT 3
`define TMC_PS_LO_BIT 4
`define TMC_PS_HI_BIT 5
`define TMC_OVF_BIT 0
`define TMC_CNT_RST 16'h0000
`define TMC_CNT_MAX 16'hFFFF
`define TMC_PS_LIM_DIV8 3'h7
`define TMC_PS_LIM_DIV4 3'h3
`define TMC_PS_LIM_DIV2 3'h1
`define TMC_PS_LIM_DIV1 3'h0
`endif

// file: tb/tmc_timer_checker.sv
// checker of the timer bus handshake, control and interrupt outputs
module tmc_timer_checker (
    // bus side
    input wire i_clock, i_rst_n, i_psel, i_penable, i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata, o_prdata,
    // timer outputs
    input wire o_pready, o_pslverr, o_osc_run, o_osc_pins_input, o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire acc = i_psel && i_penable && i_pwrite;
    wire w_ctrl = acc && i_paddr == 12'h010;
    wire w_mask = acc && i_paddr == 12'h020 && !i_pwdata[0];
    ////////////////////////////////////////////////////////////////
    property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_one; o_pready |=> !o_pready; endproperty
    a_one: assert property (p_one) else $error("ready too long");
    property p_top; o_pready && !i_pwrite && i_paddr == 12'h010 |-> !o_prdata[7:6]; endproperty
    a_top: assert property (p_top) else $error("upper control bits set");
    property p_err; o_pready && i_paddr > 12'h024 |-> o_pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    // the control bit lands at the access edge, the output one edge later
    property p_osc; w_ctrl |-> ##2 o_osc_run == $past(i_pwdata[3], 2); endproperty
    a_osc: assert property (p_osc) else $error("osc enable wrong");
    property p_hold; !w_ctrl |-> ##2 $stable(o_osc_run); endproperty
    a_hold: assert property (p_hold) else $error("osc changed alone");
    property p_pins; o_osc_pins_input == o_osc_run; endproperty
    a_pins: assert property (p_pins) else $error("pins not input");
    property p_mask; w_mask |-> ##2 !o_irq; endproperty
    a_mask: assert property (p_mask) else $error("masked irq high");
    c_osc: cover property (w_ctrl && i_pwdata[3]);
    c_irq: cover property (o_irq);
    c_err: cover property (o_pslverr);
endmodule
bind tmc_timer tmc_timer_checker u_chk (.i_clock, .i_rst_n, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_osc_run,
    .o_osc_pins_input, .o_irq);

// file: tb/tmc_clk_src.sv
// external clock pin and watch crystal at the far side of the timer
module tmc_clk_src (
    // oscillator power from the timer
    input wire i_osc_run,
    // pins toward the timer
    output logic o_ext_clock_pin = 1'b0,
    output logic o_osc_input_pin = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // crystal swings only while powered, sleep or not; far faster than real to keep runs short
    always #40 if (i_osc_run) o_osc_input_pin = !o_osc_input_pin;
    task automatic pulses(input int n);
        // callers return on a rising edge; start half a period later so the pin
        // never moves in the step in which the timer samples it
        #5;
        repeat (n) begin
            #50 o_ext_clock_pin = 1'b1;
            #50 o_ext_clock_pin = 1'b0;
        end
    endtask
endmodule

// file: tb/tmc_timer_bench.sv
// self-checking bench for the sixteen-bit timer/counter
module tmc_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic i_instr_tick = 1'b0, i_sleep = 1'b0, e;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0000_0000, q;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_osc_run, o_osc_pins_input, o_irq, ext_pin, osc_pin;
    int errors = 0, n_tests = 0;
    tmc_timer uut (.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_instr_tick, .i_sleep,
        .i_ext_clock_pin(ext_pin), .i_osc_input_pin(osc_pin), .o_osc_run,
        .o_osc_pins_input, .o_irq);
    tmc_clk_src src (.i_osc_run(o_osc_run), .o_ext_clock_pin(ext_pin),
        .o_osc_input_pin(osc_pin));
    initial forever #5 i_clock = !i_clock;
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one idle edge after each transfer keeps strobes from being driven twice at once
    task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
        int k;
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (o_pready !== 1'b1 && k < 50);
        q = o_prdata;
        e = o_pslverr;
        if (o_pready !== 1'b1) begin
            errors++;
            summarize();
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        check(q, exp);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            i_instr_tick <= 1'b1;
            @(posedge i_clock);
            i_instr_tick <= 1'b0;
            @(posedge i_clock);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        rd(12'h010, 32'h0000_0000);
        apb(12'h010, 1'b1, 32'h0000_00FF);
        rd(12'h010, 32'h0000_003F);
        repeat (20) @(posedge i_clock);
        check({31'h0, o_osc_run}, 32'h0000_0001);
        check({31'h0, o_osc_pins_input}, 32'h0000_0001);
        rd(12'h02C, 32'h0000_0000);
        check({31'h0, e}, 32'h0000_0001);
        apb(12'h010, 1'b1, 32'h0000_0000);
        @(posedge i_clock);
        check({31'h0, o_osc_run}, 32'h0000_0000);
        check({31'h0, o_osc_pins_input}, 32'h0000_0000);
        for (int ps = 0; ps < 4; ps++) begin
            apb(12'h010, 1'b1, 32'(ps * 16 + 1));
            apb(12'h014, 1'b1, 32'h0000_0000);
            ticks(8);
            apb(12'h010, 1'b1, 32'h0000_0000);
            ticks(4);
            rd(12'h014, 32'(8 >> ps));
        end
        apb(12'h020, 1'b1, 32'h0000_0001);
        apb(12'h014, 1'b1, 32'h0000_00FF);
        apb(12'h018, 1'b1, 32'h0000_00FF);
        apb(12'h010, 1'b1, 32'h0000_0001);
        ticks(1);
        rd(12'h014, 32'h0000_0000);
        rd(12'h018, 32'h0000_0000);
        rd(12'h01C, 32'h0000_0001);
        check({31'h0, o_irq}, 32'h0000_0001);
        apb(12'h020, 1'b1, 32'h0000_0000);
        @(posedge i_clock);
        check({31'h0, o_irq}, 32'h0000_0000);
        apb(12'h01C, 1'b1, 32'h0000_0001);
        rd(12'h01C, 32'h0000_0000);
        // pin starts low, so the first rise comes before any fall and must be ignored
        // s=0 synchronised awake, s=1 unsynchronised asleep, s=2 synchronised asleep
        for (int s = 0; s < 3; s++) begin
            apb(12'h010, 1'b1, 32'h0000_0000);
            apb(12'h014, 1'b1, 32'h0000_0000);
            i_sleep <= (s != 0);
            apb(12'h010, 1'b1, (s == 1) ? 32'h0000_0007 : 32'h0000_0003);
            src.pulses(5);
            repeat (10) @(posedge i_clock);
            rd(12'h014, (s == 2) ? 32'h0000_0000 : 32'h0000_0004);
            rd(12'h024, (s != 0) ? 32'h0000_0001 : 32'h0000_0000);
            i_sleep <= 1'b0;
        end
        // reset in mid-run brings the control register back to zero
        apb(12'h010, 1'b1, 32'h0000_003F);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        rd(12'h010, 32'h0000_0000);
        check({31'h0, o_osc_run}, 32'h0000_0000);
        summarize();
    end
endmodule
